// File: cmdp_top.sv
/*
 * cmdp_top: clamp and move execution datapath with its register file, reached
 * over an Avalon-MM slave with waitrequest.
 * assumes a master that holds each request until waitrequest is seen low and
 * never raises read and write together.
 */
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/1ns

// Summary of operation
// - upper unsigned clamp keeps the unsigned smaller of destination and source
// - upper signed clamp keeps the signed smaller of destination and source
// - lower unsigned clamp keeps the unsigned larger of destination and source
// - lower signed clamp keeps the signed larger of destination and source
// - clamps with zero option set zero when original operands are equal
// - unsigned clamps with carry option set carry when destination unsigned-below source
// - signed clamps with carry option set carry when destination signed-below source
// - result goes to destination unless no-result; flags follow own options
// - source is the addressed register or the 9-bit field zero-extended
// - whole copy gives the source value unchanged
// - whole copy flags: zero when source is zero, carry takes source top bit
// - destination-field insert replaces bits 17..9 with low nine source bits
// - instruction-field insert replaces bits 31..23 with low nine source bits
// - source-field insert replaces bits 8..0 with low nine source bits
// - inserts with zero option set zero when the inserted nine bits are zero
module cmdp_top #(
	parameter int REG_AW = 9
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [cmdp_pkg::BUS_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [cmdp_pkg::DATA_W-1:0] avs_writedata,
	output logic [cmdp_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest
);

	////////////////////////////////////////////////////////////////////////////////
	// elaboration check: register fields address the file directly
	generate
		if (REG_AW != cmdp_pkg::FIELD_W) begin : g_bad_aw
			$error("cmdp_top: REG_AW must equal the 9-bit register field width");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// opcode class decoders
	function automatic logic isClampOp(input logic [cmdp_pkg::OPC_W-1:0] op);
		isClampOp = (op == cmdp_pkg::OPC_CLAMP_UPPER_UNSIGNED) ||
			(op == cmdp_pkg::OPC_CLAMP_UPPER_SIGNED) ||
			(op == cmdp_pkg::OPC_CLAMP_LOWER_UNSIGNED) ||
			(op == cmdp_pkg::OPC_CLAMP_LOWER_SIGNED);
	endfunction

	function automatic logic isInsertOp(input logic [cmdp_pkg::OPC_W-1:0] op);
		isInsertOp = (op == cmdp_pkg::OPC_INSERT_DEST_FIELD) ||
			(op == cmdp_pkg::OPC_INSERT_INSTR_FIELD) ||
			(op == cmdp_pkg::OPC_INSERT_SRC_FIELD);
	endfunction

	function automatic logic isUnsignedClampOp(input logic [cmdp_pkg::OPC_W-1:0] op);
		isUnsignedClampOp = (op == cmdp_pkg::OPC_CLAMP_UPPER_UNSIGNED) ||
			(op == cmdp_pkg::OPC_CLAMP_LOWER_UNSIGNED);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// state
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD_DEST,
		ST_RD_SRC,
		ST_EXEC,
		ST_MEM_WAIT,
		ST_ANSWER
	} cmdp_state_e;

	cmdp_state_e state;
	cmdp_state_e next_state;
	logic [cmdp_pkg::DATA_W-1:0] instrReg;
	logic [cmdp_pkg::DATA_W-1:0] dReg;
	logic [cmdp_pkg::DATA_W-1:0] sReg;
	logic [cmdp_pkg::DATA_W-1:0] resultReg;
	logic zeroNew;
	logic carryNew;
	logic carryValidReg;
	logic legalReg;
	logic execActive;
	logic zeroFlag;
	logic carryFlag;
	logic lastIllegal;
	logic lastWrote;
	logic [cmdp_pkg::FIELD_W-1:0] regIndex;
	logic [cmdp_pkg::DATA_W-1:0] readData;

	cmdp_mem_if #(.AW(REG_AW), .DW(cmdp_pkg::DATA_W)) memBus ();
	cmdp_alu_if aluBus ();

	cmdp_regfile #(.AW(REG_AW), .DW(cmdp_pkg::DATA_W)) u_regfile (
		.clk(clk),
		.mem(memBus)
	);

	cmdp_alu u_alu (
		.a(aluBus)
	);

	////////////////////////////////////////////////////////////////////////////////
	// decode
	wire logic [cmdp_pkg::OPC_W-1:0] opcode;
	wire logic [cmdp_pkg::FIELD_W-1:0] destField;
	wire logic [cmdp_pkg::FIELD_W-1:0] srcField;
	wire logic zeroOpt;
	wire logic carryOpt;
	wire logic resultOpt;
	wire logic immOpt;
	wire logic [cmdp_pkg::DATA_W-1:0] srcOperand;
	wire logic reqInstrWrite;
	wire logic reqDataRead;
	wire logic reqAny;
	wire logic answering;
	wire logic ansExec;
	wire logic ansBusWrite;
	wire logic writeBack;
	wire logic [cmdp_pkg::DATA_W-1:0] readMux;
	wire logic [cmdp_pkg::DATA_W-1:0] statusWord;
	wire logic [cmdp_pkg::DATA_W-1:0] flagsWord;

	assign opcode = instrReg[cmdp_pkg::OPC_HI:cmdp_pkg::OPC_LO];
	assign destField = instrReg[cmdp_pkg::DEST_HI:cmdp_pkg::DEST_LO];
	assign srcField = instrReg[cmdp_pkg::SRC_HI:cmdp_pkg::SRC_LO];
	assign zeroOpt = instrReg[cmdp_pkg::ZOPT_BIT];
	assign carryOpt = instrReg[cmdp_pkg::COPT_BIT];
	assign resultOpt = instrReg[cmdp_pkg::RES_BIT];
	assign immOpt = instrReg[cmdp_pkg::IMM_BIT];

	assign srcOperand = immOpt ?
		{{(cmdp_pkg::DATA_W-cmdp_pkg::FIELD_W){1'b0}}, srcField} :
		memBus.rdData;

	assign reqInstrWrite = avs_write && (avs_address == cmdp_pkg::REG_INSTR);
	assign reqDataRead = avs_read && (avs_address == cmdp_pkg::REG_DATA);
	assign reqAny = avs_read || avs_write;
	assign answering = state == ST_ANSWER;
	assign ansExec = answering && execActive;
	assign ansBusWrite = answering && !execActive && avs_write;
	// a cleared result option means the destination is left as it was
	assign writeBack = ansExec && legalReg && resultOpt;

	assign flagsWord = {30'h00000000, carryFlag, zeroFlag};
	assign statusWord = {30'h00000000, lastWrote, lastIllegal};
	assign readMux = (avs_address == cmdp_pkg::REG_INSTR) ? instrReg :
		(avs_address == cmdp_pkg::REG_FLAGS) ? flagsWord :
		(avs_address == cmdp_pkg::REG_STATUS) ? statusWord :
		(avs_address == cmdp_pkg::REG_INDEX) ? {23'h000000, regIndex} :
		(avs_address == cmdp_pkg::REG_RESULT) ? resultReg :
		32'h00000000;

	// one access at a time: the file read port is shared by execution and software
	assign memBus.rdAddr = (state == ST_RD_DEST) ? destField :
		(state == ST_RD_SRC) ? srcField :
		regIndex;
	assign memBus.wrEn = writeBack ||
		(ansBusWrite && (avs_address == cmdp_pkg::REG_DATA));
	assign memBus.wrAddr = execActive ? destField : regIndex;
	assign memBus.wrData = execActive ? resultReg : avs_writedata;

	assign aluBus.opcode = opcode;
	assign aluBus.dVal = dReg;
	assign aluBus.sVal = srcOperand;

	assign avs_waitrequest = !answering;
	assign avs_readdata = readData;

	////////////////////////////////////////////////////////////////////////////////
	// sequencing
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (reqInstrWrite) begin
					next_state = ST_RD_DEST;
				end else if (reqDataRead) begin
					next_state = ST_MEM_WAIT;
				end else if (reqAny) begin
					next_state = ST_ANSWER;
				end
			end
			ST_RD_DEST: next_state = ST_RD_SRC;
			ST_RD_SRC: next_state = ST_EXEC;
			ST_EXEC: next_state = ST_ANSWER;
			ST_MEM_WAIT: next_state = ST_ANSWER;
			ST_ANSWER: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// instruction capture and operand fetch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			instrReg <= cmdp_pkg::INSTR_RST;
			execActive <= 1'b0;
			dReg <= 32'h00000000;
		end else begin
			if (state == ST_IDLE) begin
				execActive <= reqInstrWrite;
				if (reqInstrWrite) begin
					instrReg <= avs_writedata;
				end
			end
			if (state == ST_RD_SRC) begin
				dReg <= memBus.rdData;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sReg <= 32'h00000000;
			resultReg <= 32'h00000000;
			zeroNew <= 1'b0;
			carryNew <= 1'b0;
			carryValidReg <= 1'b0;
			legalReg <= 1'b0;
		end else if (state == ST_EXEC) begin
			sReg <= srcOperand;
			resultReg <= aluBus.result;
			zeroNew <= aluBus.zero;
			carryNew <= aluBus.carry;
			carryValidReg <= aluBus.carryValid;
			legalReg <= aluBus.legal;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// flags and status: effects land only on the answering edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			zeroFlag <= cmdp_pkg::FLAG_RST;
			carryFlag <= cmdp_pkg::FLAG_RST;
		end else if (ansExec && legalReg) begin
			if (zeroOpt) begin
				zeroFlag <= zeroNew;
			end
			if (carryOpt && carryValidReg) begin
				carryFlag <= carryNew;
			end
		end else if (ansBusWrite && (avs_address == cmdp_pkg::REG_FLAGS)) begin
			zeroFlag <= avs_writedata[cmdp_pkg::FLAG_Z_BIT];
			carryFlag <= avs_writedata[cmdp_pkg::FLAG_C_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lastIllegal <= 1'b0;
			lastWrote <= 1'b0;
			regIndex <= cmdp_pkg::INDEX_RST;
		end else begin
			if (ansExec) begin
				lastIllegal <= !legalReg;
				lastWrote <= writeBack;
			end
			if (ansBusWrite && (avs_address == cmdp_pkg::REG_INDEX)) begin
				regIndex <= avs_writedata[cmdp_pkg::FIELD_W-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			readData <= 32'h00000000;
		end else if (state == ST_MEM_WAIT) begin
			readData <= memBus.rdData;
		end else if ((state == ST_IDLE) && avs_read && !reqDataRead) begin
			readData <= readMux;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks, sampled on the answering cycle of an execution
	wire logic ansClamp;
	wire logic ansIns;
	assign ansClamp = ansExec && isClampOp(opcode);
	assign ansIns = ansExec && isInsertOp(opcode);

	AST_UPPER_UNSIGNED: assert property (@(posedge clk) disable iff (!rst_n)
		ansExec && (opcode == cmdp_pkg::OPC_CLAMP_UPPER_UNSIGNED)
		|-> resultReg == ((dReg < sReg) ? dReg : sReg))
		else $error("upper unsigned clamp result wrong");
	AST_UPPER_SIGNED: assert property (@(posedge clk) disable iff (!rst_n)
		ansExec && (opcode == cmdp_pkg::OPC_CLAMP_UPPER_SIGNED)
		|-> resultReg == (($signed(dReg) < $signed(sReg)) ? dReg : sReg))
		else $error("upper signed clamp result wrong");
	AST_LOWER_UNSIGNED: assert property (@(posedge clk) disable iff (!rst_n)
		ansExec && (opcode == cmdp_pkg::OPC_CLAMP_LOWER_UNSIGNED)
		|-> resultReg == ((dReg < sReg) ? sReg : dReg))
		else $error("lower unsigned clamp result wrong");
	AST_LOWER_SIGNED: assert property (@(posedge clk) disable iff (!rst_n)
		ansExec && (opcode == cmdp_pkg::OPC_CLAMP_LOWER_SIGNED)
		|-> resultReg == (($signed(dReg) < $signed(sReg)) ? sReg : dReg))
		else $error("lower signed clamp result wrong");
	AST_CLAMP_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
		ansClamp && zeroOpt |=> zeroFlag == ($past(dReg) == $past(sReg)))
		else $error("clamp zero flag wrong");
	AST_UCLAMP_CARRY: assert property (@(posedge clk) disable iff (!rst_n)
		ansClamp && isUnsignedClampOp(opcode) && carryOpt
		|=> carryFlag == ($past(dReg) < $past(sReg)))
		else $error("unsigned clamp carry wrong");
	AST_SCLAMP_CARRY: assert property (@(posedge clk) disable iff (!rst_n)
		ansClamp && !isUnsignedClampOp(opcode) && carryOpt
		|=> carryFlag == ($signed($past(dReg)) < $signed($past(sReg))))
		else $error("signed clamp carry wrong");
	AST_NO_RESULT: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_RD_DEST ##1 state == ST_RD_SRC ##1 state == ST_EXEC ##1 !resultOpt
		|-> !memBus.wrEn)
		else $error("destination written under no-result");
	AST_IMM_SOURCE: assert property (@(posedge clk) disable iff (!rst_n)
		ansExec && immOpt |-> sReg == {23'h000000, srcField})
		else $error("immediate source not zero-extended");
	AST_COPY: assert property (@(posedge clk) disable iff (!rst_n)
		ansExec && (opcode == cmdp_pkg::OPC_COPY_WHOLE) |-> resultReg == sReg)
		else $error("whole copy result wrong");
	AST_COPY_FLAGS: assert property (@(posedge clk) disable iff (!rst_n)
		ansExec && (opcode == cmdp_pkg::OPC_COPY_WHOLE) && zeroOpt && carryOpt
		|=> zeroFlag == ($past(sReg) == 32'h00000000) && carryFlag == $past(sReg[31]))
		else $error("whole copy flags wrong");
	AST_INS_DEST: assert property (@(posedge clk) disable iff (!rst_n)
		ansExec && (opcode == cmdp_pkg::OPC_INSERT_DEST_FIELD)
		|-> resultReg[17:9] == sReg[8:0] && resultReg[31:18] == dReg[31:18]
		&& resultReg[8:0] == dReg[8:0])
		else $error("destination field insert wrong");
	AST_INS_INSTR: assert property (@(posedge clk) disable iff (!rst_n)
		ansExec && (opcode == cmdp_pkg::OPC_INSERT_INSTR_FIELD)
		|-> resultReg[31:23] == sReg[8:0] && resultReg[22:0] == dReg[22:0])
		else $error("instruction field insert wrong");
	AST_INS_SRC: assert property (@(posedge clk) disable iff (!rst_n)
		ansExec && (opcode == cmdp_pkg::OPC_INSERT_SRC_FIELD)
		|-> resultReg[8:0] == sReg[8:0] && resultReg[31:9] == dReg[31:9])
		else $error("source field insert wrong");
	AST_INS_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
		ansIns && zeroOpt |=> zeroFlag == ($past(sReg[8:0]) == 9'h000))
		else $error("insert zero flag wrong");
	AST_INS_CARRY: assert property (@(posedge clk) disable iff (!rst_n)
		ansIns |=> $stable(carryFlag))
		else $error("insert changed carry");

endmodule

// File: cmdp_pkg.sv
/*
 * cmdp_pkg: shared constants of the clamp and move datapath: bus map, instruction
 * word layout, opcodes, flag and status bit positions, reset values.
 * assumes a 32-bit instruction word and a 9-bit register address field.
 */
package cmdp_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// widths
	localparam int DATA_W = 32;
	localparam int FIELD_W = 9;
	localparam int BUS_AW = 8;
	localparam int OPC_W = 6;

	////////////////////////////////////////////////////////////////////////////////
	// instruction word layout
	localparam int OPC_HI = 31;
	localparam int OPC_LO = 26;
	localparam int ZOPT_BIT = 25;
	localparam int COPT_BIT = 24;
	localparam int RES_BIT = 23;
	localparam int IMM_BIT = 22;
	localparam int DEST_HI = 17;
	localparam int DEST_LO = 9;
	localparam int SRC_HI = 8;
	localparam int SRC_LO = 0;
	localparam int INSF_HI = 31;
	localparam int INSF_LO = 23;

	////////////////////////////////////////////////////////////////////////////////
	// opcodes
	localparam logic [OPC_W-1:0] OPC_CLAMP_UPPER_UNSIGNED = 6'h13;
	localparam logic [OPC_W-1:0] OPC_CLAMP_UPPER_SIGNED = 6'h11;
	localparam logic [OPC_W-1:0] OPC_CLAMP_LOWER_UNSIGNED = 6'h12;
	localparam logic [OPC_W-1:0] OPC_CLAMP_LOWER_SIGNED = 6'h10;
	localparam logic [OPC_W-1:0] OPC_COPY_WHOLE = 6'h28;
	localparam logic [OPC_W-1:0] OPC_INSERT_DEST_FIELD = 6'h15;
	localparam logic [OPC_W-1:0] OPC_INSERT_INSTR_FIELD = 6'h16;
	localparam logic [OPC_W-1:0] OPC_INSERT_SRC_FIELD = 6'h14;

	////////////////////////////////////////////////////////////////////////////////
	// register map, byte addresses
	localparam logic [BUS_AW-1:0] REG_INSTR = 8'h00;
	localparam logic [BUS_AW-1:0] REG_FLAGS = 8'h04;
	localparam logic [BUS_AW-1:0] REG_STATUS = 8'h08;
	localparam logic [BUS_AW-1:0] REG_INDEX = 8'h0C;
	localparam logic [BUS_AW-1:0] REG_DATA = 8'h10;
	localparam logic [BUS_AW-1:0] REG_RESULT = 8'h14;

	localparam int FLAG_Z_BIT = 0;
	localparam int FLAG_C_BIT = 1;
	localparam int STAT_ILLEGAL_BIT = 0;
	localparam int STAT_WROTE_BIT = 1;

	localparam logic [DATA_W-1:0] INSTR_RST = 32'h00000000;
	localparam logic FLAG_RST = 1'h0;
	localparam logic [FIELD_W-1:0] INDEX_RST = 9'h000;

endpackage

// File: cmdp_ifs.sv
/*
 * cmdp_ifs: carriers between the datapath controller, its operation unit and
 * its register file.
 * assumes both ends sit on the same clock.
 */
`timescale 1ns/1ns

interface cmdp_mem_if #(parameter int AW = 9, parameter int DW = 32);
	logic wrEn;
	logic [AW-1:0] wrAddr;
	logic [DW-1:0] wrData;
	logic [AW-1:0] rdAddr;
	logic [DW-1:0] rdData;
	modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
	modport mem (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

interface cmdp_alu_if;
	logic [cmdp_pkg::OPC_W-1:0] opcode;
	logic [cmdp_pkg::DATA_W-1:0] dVal;
	logic [cmdp_pkg::DATA_W-1:0] sVal;
	logic [cmdp_pkg::DATA_W-1:0] result;
	logic zero;
	logic carry;
	logic carryValid;
	logic legal;
	modport ctrl (output opcode, output dVal, output sVal,
		input result, input zero, input carry, input carryValid, input legal);
	modport alu (input opcode, input dVal, input sVal,
		output result, output zero, output carry, output carryValid, output legal);
endinterface

// File: cmdp_regfile.sv
/*
 * cmdp_regfile: core register file, one write port, one read port with registered
 * read data (one cycle from address to data).
 * assumes the controller never needs read-during-write forwarding.
 */
`timescale 1ns/1ns

module cmdp_regfile #(
	parameter int AW = 9,
	parameter int DW = 32
) (
	input wire logic clk,
	cmdp_mem_if.mem mem
);

	logic [DW-1:0] store [0:(1<<AW)-1];
	logic [DW-1:0] rdData;

	// no reset on the array: contents are software state
	always_ff @(posedge clk) begin
		if (mem.wrEn) begin
			store[mem.wrAddr] <= mem.wrData;
		end
		rdData <= store[mem.rdAddr];
	end

	assign mem.rdData = rdData;

endmodule

// File: cmdp_alu.sv
/*
 * cmdp_alu: combinational result and flag unit for clamps, whole copy and
 * field inserts.
 * assumes operands are already selected (immediate already zero-extended).
 */
`timescale 1ns/1ns

module cmdp_alu (
	cmdp_alu_if.alu a
);

	wire logic uLess;
	wire logic sLess;
	wire logic same;
	wire logic isUU;
	wire logic isUS;
	wire logic isLU;
	wire logic isLS;
	wire logic isCopy;
	wire logic isInsD;
	wire logic isInsI;
	wire logic isInsS;
	wire logic isClamp;
	wire logic isIns;
	wire logic [cmdp_pkg::FIELD_W-1:0] field;

	assign uLess = a.dVal < a.sVal;
	assign sLess = $signed(a.dVal) < $signed(a.sVal);
	assign same = a.dVal == a.sVal;
	assign field = a.sVal[cmdp_pkg::FIELD_W-1:0];
	assign isUU = a.opcode == cmdp_pkg::OPC_CLAMP_UPPER_UNSIGNED;
	assign isUS = a.opcode == cmdp_pkg::OPC_CLAMP_UPPER_SIGNED;
	assign isLU = a.opcode == cmdp_pkg::OPC_CLAMP_LOWER_UNSIGNED;
	assign isLS = a.opcode == cmdp_pkg::OPC_CLAMP_LOWER_SIGNED;
	assign isCopy = a.opcode == cmdp_pkg::OPC_COPY_WHOLE;
	assign isInsD = a.opcode == cmdp_pkg::OPC_INSERT_DEST_FIELD;
	assign isInsI = a.opcode == cmdp_pkg::OPC_INSERT_INSTR_FIELD;
	assign isInsS = a.opcode == cmdp_pkg::OPC_INSERT_SRC_FIELD;
	assign isClamp = isUU | isUS | isLU | isLS;
	assign isIns = isInsD | isInsI | isInsS;

	////////////////////////////////////////////////////////////////////////////////
	// result select
	assign a.result = isUU ? (uLess ? a.dVal : a.sVal) :
		isUS ? (sLess ? a.dVal : a.sVal) :
		isLU ? (uLess ? a.sVal : a.dVal) :
		isLS ? (sLess ? a.sVal : a.dVal) :
		isCopy ? a.sVal :
		isInsD ? {a.dVal[31:18], field, a.dVal[8:0]} :
		isInsI ? {field, a.dVal[22:0]} :
		isInsS ? {a.dVal[31:9], field} :
		a.dVal;

	////////////////////////////////////////////////////////////////////////////////
	// flags
	assign a.zero = isClamp ? same :
		isCopy ? (a.sVal == 32'h00000000) :
		(field == 9'h000);
	assign a.carry = (isUU | isLU) ? uLess :
		(isUS | isLS) ? sLess :
		a.sVal[cmdp_pkg::DATA_W-1];
	// inserts define no carry, so the flag must be left alone
	assign a.carryValid = isClamp | isCopy;
	assign a.legal = isClamp | isCopy | isIns;

endmodule

// File: tb.sv
/*
 * tb: self-checking bench for cmdp_top, drives clamps, copy and inserts over avalon.
 * assumes cmdp_pkg and the design files are compiled before it.
 */
`timescale 1ns/1ns

module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] avsAddress = 8'h00;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWritedata = 32'h00000000;
	logic [31:0] avsReaddata;
	logic avsWaitrequest;
	logic [31:0] rv;
	int n_fail = 0;
	int check_count = 0;

	cmdp_top #(.REG_AW(9)) uut (.clk(clk), .rst_n(rst_n), .avs_address(avsAddress),
		.avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
		.avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest));

	always #5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	task finish_test;
		if (n_fail == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// request stands until the rising edge at which waitrequest is seen low
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avsAddress <= a;
		avsWrite <= wr;
		avsRead <= !wr;
		avsWritedata <= d;
		do begin
			@(posedge clk);
			n++;
			if (n > 50) begin
				n_fail++;
				break;
			end
		end while (avsWaitrequest !== 1'b0);
		rv = avsReaddata;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
	endtask

	task set_reg(input logic [8:0] idx, input logic [31:0] v);
		bus(1'b1, cmdp_pkg::REG_INDEX, {23'h0, idx});
		bus(1'b1, cmdp_pkg::REG_DATA, v);
	endtask

	task get_reg(input logic [8:0] idx);
		bus(1'b1, cmdp_pkg::REG_INDEX, {23'h0, idx});
		bus(1'b0, cmdp_pkg::REG_DATA, 32'h0);
	endtask

	task exec(input logic [5:0] op, input logic [3:0] zcri, input logic [8:0] d,
		input logic [8:0] s);
		bus(1'b1, cmdp_pkg::REG_INSTR, {op, zcri, 4'h0, d, s});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task test_clamps;
		logic [5:0] ops [4];
		logic [31:0] dv [3];
		logic [31:0] sv [3];
		logic lt;
		logic [31:0] ex;
		ops = '{cmdp_pkg::OPC_CLAMP_UPPER_UNSIGNED, cmdp_pkg::OPC_CLAMP_UPPER_SIGNED,
			cmdp_pkg::OPC_CLAMP_LOWER_UNSIGNED, cmdp_pkg::OPC_CLAMP_LOWER_SIGNED};
		dv = '{32'h80000000, 32'h00000007, 32'h12345678};
		sv = '{32'h00000005, 32'hFFFFFFF0, 32'h12345678};
		foreach (ops[i]) begin
			foreach (dv[j]) begin
				// opcode bit 1 marks unsigned, bit 0 the upper clamp
				lt = ops[i][1] ? (dv[j] < sv[j]) : ($signed(dv[j]) < $signed(sv[j]));
				ex = (ops[i][0] ~^ lt) ? dv[j] : sv[j];
				// preset flags opposite so a missed update shows
				bus(1'b1, cmdp_pkg::REG_FLAGS, {30'h0, !lt, dv[j] != sv[j]});
				set_reg(9'h001, dv[j]);
				set_reg(9'h002, sv[j]);
				exec(ops[i], 4'hE, 9'h001, 9'h002);
				get_reg(9'h001);
				check("clamp dest", rv, ex);
				bus(1'b0, cmdp_pkg::REG_FLAGS, 32'h0);
				check("clamp flags", rv, {30'h0, lt, dv[j] == sv[j]});
			end
		end
	endtask

	task test_imm_nores;
		set_reg(9'h003, 32'h00000100);
		bus(1'b1, cmdp_pkg::REG_FLAGS, 32'h00000001);
		exec(cmdp_pkg::OPC_CLAMP_LOWER_UNSIGNED, 4'hD, 9'h003, 9'h1FF);
		bus(1'b0, cmdp_pkg::REG_RESULT, 32'h0);
		check("imm result", rv, 32'h000001FF);
		get_reg(9'h003);
		check("nores dest", rv, 32'h00000100);
		bus(1'b0, cmdp_pkg::REG_FLAGS, 32'h0);
		check("nores flags", rv, 32'h00000002);
	endtask

	task test_copy;
		logic [31:0] v [2];
		v = '{32'h80000000, 32'h00000000};
		foreach (v[i]) begin
			bus(1'b1, cmdp_pkg::REG_FLAGS, {30'h0, !v[i][31], v[i] != 0});
			set_reg(9'h004, v[i]);
			set_reg(9'h005, 32'hAAAA5555);
			exec(cmdp_pkg::OPC_COPY_WHOLE, 4'hE, 9'h005, 9'h004);
			get_reg(9'h005);
			check("copy dest", rv, v[i]);
			bus(1'b0, cmdp_pkg::REG_FLAGS, 32'h0);
			check("copy flags", rv, {30'h0, v[i][31], v[i] == 0});
		end
	endtask

	task test_inserts;
		logic [5:0] ops [3];
		int lo [3];
		logic [31:0] sv [2];
		logic [31:0] ex;
		ops = '{cmdp_pkg::OPC_INSERT_DEST_FIELD, cmdp_pkg::OPC_INSERT_INSTR_FIELD,
			cmdp_pkg::OPC_INSERT_SRC_FIELD};
		lo = '{9, 23, 0};
		sv = '{32'h12345A00, 32'h00000135};
		foreach (ops[i]) begin
			foreach (sv[j]) begin
				ex = (32'hA5A5A5A5 & ~(32'h000001FF << lo[i])) | ({23'h0, sv[j][8:0]} << lo[i]);
				bus(1'b1, cmdp_pkg::REG_FLAGS, {30'h0, 1'b1, sv[j][8:0] != 0});
				set_reg(9'h006, 32'hA5A5A5A5);
				set_reg(9'h007, sv[j]);
				exec(ops[i], 4'hE, 9'h006, 9'h007);
				get_reg(9'h006);
				check("insert dest", rv, ex);
				bus(1'b0, cmdp_pkg::REG_FLAGS, 32'h0);
				check("insert flags", rv, {30'h0, 1'b1, sv[j][8:0] == 0});
			end
		end
		bus(1'b0, 8'h40, 32'h0);
		check("unmapped read", rv, 32'h00000000);
	endtask

	// an opcode outside the block's set must leave destination and flags unchanged and set status
	task test_status;
		set_reg(9'h008, 32'h0000ABCD);
		bus(1'b1, cmdp_pkg::REG_FLAGS, 32'h00000003);
		exec(6'h3F, 4'hE, 9'h008, 9'h008);
		get_reg(9'h008);
		check("illegal dest", rv, 32'h0000ABCD);
		bus(1'b0, cmdp_pkg::REG_FLAGS, 32'h0);
		check("illegal flags", rv, 32'h00000003);
		bus(1'b0, cmdp_pkg::REG_STATUS, 32'h0);
		check("illegal status", rv, 32'h00000001);
		exec(cmdp_pkg::OPC_COPY_WHOLE, 4'hE, 9'h008, 9'h008);
		bus(1'b0, cmdp_pkg::REG_STATUS, 32'h0);
		check("wrote status", rv, 32'h00000002);
		exec(cmdp_pkg::OPC_COPY_WHOLE, 4'hC, 9'h008, 9'h008);
		bus(1'b0, cmdp_pkg::REG_STATUS, 32'h0);
		check("nores status", rv, 32'h00000000);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		n_fail++;
		finish_test;
	end

	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		test_clamps;
		test_imm_nores;
		test_copy;
		test_inserts;
		test_status;
		finish_test;
	end
endmodule
